// ===== core/drpt_pkg.sv
// package with modes, count-source codes and reset values for the pulse timer
package drpt_pkg;
  localparam int          DRPT_W         = 8;
  localparam logic [7:0]  DRPT_RST_VAL   = 8'hff;
  localparam logic [1:0]  DRPT_SRC_F1    = 2'h0;
  localparam logic [1:0]  DRPT_SRC_F2    = 2'h1;
  localparam logic [1:0]  DRPT_SRC_F8    = 2'h2;
  localparam logic [1:0]  DRPT_SRC_CASC  = 2'h3;
  localparam logic [2:0]  DRPT_DIV8_LAST = 3'h7;
  localparam logic [7:0]  DRPT_ZERO      = 8'h00;
  typedef enum logic [1:0] {
    DRPT_MODE_WAVE  = 2'h0,
    DRPT_MODE_SHOT  = 2'h1,
    DRPT_MODE_DELAY = 2'h3
  } drpt_mode_e;
  typedef enum logic [1:0] {
    DRPT_PH_IDLE = 2'h0,
    DRPT_PH_PRI  = 2'h1,
    DRPT_PH_SEC  = 2'h3
  } drpt_phase_e;
endpackage

// ===== core/drpt_tick_if.sv
// interface carrying count-source ticks from the source selector to the timer core
`timescale 1ns/1ps
interface drpt_tick_if;
  logic       tick;
  logic       half;
  logic [1:0] sel;
  logic       run;
  modport src  (input sel, input run, output tick, output half);
  modport core (output sel, output run, input tick, input half);
endinterface

// ===== core/drpt_source.sv
// count-source selector: f1, f2, f8 or companion timer underflow
`timescale 1ns/1ps
module drpt_source
  import drpt_pkg::*;
(
  input  wire logic   clk_in,
  input  wire logic   rst_n_in,
  input  wire logic   casc_in,
  drpt_tick_if.src    tk
);
  logic [2:0] div_ff;
  logic       tick_q_ff;

  // free-running divider for the divided clocks
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_ff <= 3'h0;
    end else begin
      div_ff <= div_ff + 3'h1;
    end
  end

  // select one source as a one-cycle tick
  always_comb begin
    unique case (tk.sel)
      DRPT_SRC_F1:   tk.tick = tk.run; // RULE3
      DRPT_SRC_F2:   tk.tick = tk.run & div_ff[0];
      DRPT_SRC_F8:   tk.tick = tk.run & (div_ff == DRPT_DIV8_LAST);
      DRPT_SRC_CASC: tk.tick = tk.run & casc_in;
    endcase
  end

  // delayed tick stands for the half-cycle point of the source
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_q_ff <= 1'b0;
    end else begin
      tick_q_ff <= tk.tick;
    end
  end
  assign tk.half = tick_q_ff;
endmodule

// ===== core/drpt_timer.sv
// dual-reload 8-bit pulse timer with 8-bit prescaler
`timescale 1ns/1ps
// Overview of operation
// RULE1 - 8-bit timer behind 8-bit prescaler, reload pairs
// RULE2 - timer counts prescaler underflows, secondary too
// RULE3 - count source f1, f2, f8 or cascade
// RULE4 - waveform mode reloads primary/secondary alternately, continuous
// RULE5 - phases last (n+1)(m+1) and (n+1)(p+1)
// RULE6 - waveform interrupt half tick after secondary end
// RULE7 - writing start bit one begins counting
// RULE8 - start zero or forced stop halts
// RULE9 - output level select sets active level
// RULE10 - one-shot underflow reloads, ends, clears flag
// RULE11 - stopping one-shot reloads counter first
// RULE12 - one-shot pulse lasts (n+1)(m+1) periods
// RULE13 - one-shot starts on software or pin trigger
// RULE14 - one-shot ends four ways
// RULE15 - one-shot interrupt half tick after underflow
// RULE16 - delayed mode primary underflow loads secondary
// RULE17 - delayed secondary underflow reloads primary, clears flag
// RULE18 - wait (n+1)(m+1), pulse (n+1)(p+1)
// RULE19 - delayed mode ends after secondary or stops
// RULE20 - delayed interrupt half tick after secondary
// RULE21 - reads give counters, writes load reloads
// RULE22 - pin triggers ignored while shot active
module drpt_timer
  import drpt_pkg::*;
(
  input  wire logic       CLK_IN,
  input  wire logic       RST_N_IN,
  input  wire logic [1:0] MODE_IN,
  input  wire logic [1:0] SRC_SEL_IN,
  input  wire logic       CASC_UNDERFLOW_IN,
  input  wire logic       COUNT_START_BIT_IN,
  input  wire logic       FORCED_STOP_WR_IN,
  input  wire logic       ONE_SHOT_START_WR_IN,
  input  wire logic       ONE_SHOT_STOP_WR_IN,
  input  wire logic       OUTPUT_LEVEL_SELECT_IN,
  input  wire logic       EXTERNAL_TRIGGER_PIN_IN,
  input  wire logic       PRE_WR_IN,
  input  wire logic       PRI_WR_IN,
  input  wire logic       SEC_WR_IN,
  input  wire logic [7:0] WR_DATA_IN,
  output logic      [7:0] PRESCALE_STAGE_OUT,
  output logic      [7:0] PRIMARY_COUNTER_OUT,
  output logic            COUNT_ACTIVE_OUT,
  output logic            ONE_SHOT_STATUS_FLAG_OUT,
  output logic            PULSE_OUTPUT_PIN_OUT,
  output logic            IRQ_OUT
);
  drpt_tick_if tk ();

  logic [7:0]  pre_rld_ff;
  logic [7:0]  pri_rld_ff;
  logic [7:0]  sec_rld_ff;
  logic [7:0]  pre_cnt_ff;
  logic [7:0]  tmr_cnt_ff;
  logic        start_ff;
  logic        shot_ff;
  logic        active_ff;
  logic        end_pend_ff;
  logic        pin_lvl_ff;
  logic        irq_ff;
  logic [2:0]  trg_sync_ff;
  logic        trg_old_ff;
  drpt_phase_e phase_ff;
  drpt_mode_e  mode;
  logic        stop_req;
  logic        pre_uf;
  logic        tmr_uf;
  logic        trg_edge;
  logic        shot_go;
  logic        running;

  // count-source selector
  drpt_source u_src (
    .clk_in   (CLK_IN),
    .rst_n_in (RST_N_IN),
    .casc_in  (CASC_UNDERFLOW_IN),
    .tk       (tk.src)
  );

  // mode decode, undefined code treated as waveform
  always_comb begin
    unique case (MODE_IN)
      DRPT_MODE_SHOT:  mode = DRPT_MODE_SHOT;
      DRPT_MODE_DELAY: mode = DRPT_MODE_DELAY;
      default:         mode = DRPT_MODE_WAVE;
    endcase
  end

  // underflow test used by both counter stages
  function automatic logic drpt_uf(input logic [7:0] cnt);
    drpt_uf = (cnt == DRPT_ZERO);
  endfunction

  // count-start bit as written by software
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      start_ff <= 1'b0;
    end else if (FORCED_STOP_WR_IN) begin
      start_ff <= 1'b0; // RULE8
    end else begin
      start_ff <= COUNT_START_BIT_IN; // RULE7
    end
  end

  // external trigger synchroniser and rising-edge detect
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      trg_sync_ff <= 3'h0;
      trg_old_ff  <= 1'b0;
    end else begin
      trg_sync_ff <= {trg_sync_ff[1:0], EXTERNAL_TRIGGER_PIN_IN};
      if (trg_sync_ff[2] == trg_sync_ff[1]) begin
        trg_old_ff <= trg_sync_ff[1];
      end
    end
  end

  // stop sources and shot trigger
  assign stop_req = ~COUNT_START_BIT_IN | FORCED_STOP_WR_IN; // RULE8 RULE14 RULE19
  assign trg_edge = (trg_sync_ff[2] == trg_sync_ff[1]) & trg_sync_ff[1] & ~trg_old_ff;
  assign shot_go  = start_ff & ~stop_req & ~shot_ff & (mode != DRPT_MODE_WAVE)
                  & (ONE_SHOT_START_WR_IN | trg_edge); // RULE13 RULE22
  assign running  = start_ff & ~stop_req & ((mode == DRPT_MODE_WAVE) | shot_ff);
  assign tk.sel   = SRC_SEL_IN;
  assign tk.run   = running;
  // no underflow while the timer stage is still loading its first value
  assign pre_uf   = tk.tick & (phase_ff != DRPT_PH_IDLE) & drpt_uf(pre_cnt_ff); // RULE2
  assign tmr_uf   = pre_uf & drpt_uf(tmr_cnt_ff);

  // reload registers written by software
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pre_rld_ff <= DRPT_RST_VAL;
      pri_rld_ff <= DRPT_RST_VAL;
      sec_rld_ff <= DRPT_RST_VAL;
    end else begin
      if (PRE_WR_IN) begin
        pre_rld_ff <= WR_DATA_IN; // RULE21
      end
      if (PRI_WR_IN) begin
        pri_rld_ff <= WR_DATA_IN;
      end
      if (SEC_WR_IN) begin
        sec_rld_ff <= WR_DATA_IN;
      end
    end
  end

  // prescaler stage: n+1 source ticks per underflow
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pre_cnt_ff <= DRPT_RST_VAL;
    end else if (!running || PRE_WR_IN) begin
      pre_cnt_ff <= PRE_WR_IN ? WR_DATA_IN : pre_rld_ff; // RULE1
    end else if (tk.tick && (phase_ff != DRPT_PH_IDLE)) begin
      pre_cnt_ff <= drpt_uf(pre_cnt_ff) ? pre_rld_ff : pre_cnt_ff - 8'h01; // RULE5 RULE12
    end
  end

  // timer stage and phase sequencing
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      tmr_cnt_ff <= DRPT_RST_VAL;
      phase_ff   <= DRPT_PH_IDLE;
    end else if (!running) begin
      tmr_cnt_ff <= pri_rld_ff; // RULE11
      phase_ff   <= DRPT_PH_IDLE;
    end else if (phase_ff == DRPT_PH_IDLE) begin
      tmr_cnt_ff <= pri_rld_ff;
      phase_ff   <= DRPT_PH_PRI;
    end else if (tmr_uf) begin
      unique case (mode)
        DRPT_MODE_WAVE: begin
          tmr_cnt_ff <= (phase_ff == DRPT_PH_PRI) ? sec_rld_ff : pri_rld_ff; // RULE4
          phase_ff   <= (phase_ff == DRPT_PH_PRI) ? DRPT_PH_SEC : DRPT_PH_PRI;
        end
        DRPT_MODE_SHOT: begin
          tmr_cnt_ff <= pri_rld_ff; // RULE10 RULE12
          phase_ff   <= DRPT_PH_IDLE;
        end
        DRPT_MODE_DELAY: begin
          if (phase_ff == DRPT_PH_PRI) begin
            tmr_cnt_ff <= sec_rld_ff; // RULE16 RULE18
            phase_ff   <= DRPT_PH_SEC;
          end else begin
            tmr_cnt_ff <= pri_rld_ff; // RULE17
            phase_ff   <= DRPT_PH_IDLE;
          end
        end
      endcase
    end else if (pre_uf) begin
      tmr_cnt_ff <= tmr_cnt_ff - 8'h01; // RULE2
    end
  end

  // one-shot status flag: start wins over a one-shot stop write, ends on final underflow or stop
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      shot_ff <= 1'b0;
    end else if (shot_go) begin
      shot_ff <= 1'b1; // RULE13
    end else if (stop_req || ONE_SHOT_STOP_WR_IN) begin
      shot_ff <= 1'b0; // RULE14 RULE19
    end else if (tmr_uf && (mode == DRPT_MODE_SHOT)) begin
      shot_ff <= 1'b0; // RULE10 RULE14
    end else if (tmr_uf && (mode == DRPT_MODE_DELAY) && (phase_ff == DRPT_PH_SEC)) begin
      shot_ff <= 1'b0; // RULE17 RULE19
    end
  end

  // end-of-cycle event waits for the half-cycle point
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      end_pend_ff <= 1'b0;
    end else if (tmr_uf && ((mode == DRPT_MODE_SHOT) || (phase_ff == DRPT_PH_SEC))) begin
      end_pend_ff <= 1'b1;
    end else if (tk.half || !running) begin
      end_pend_ff <= 1'b0; // stale end event must not fire on the next start
    end
  end

  // pin level and interrupt change together at the half-cycle point
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pin_lvl_ff <= 1'b0;
      irq_ff     <= 1'b0;
    end else begin
      irq_ff <= end_pend_ff & tk.half; // RULE6 RULE15 RULE20
      if (!running) begin
        pin_lvl_ff <= 1'b0;
      end else if (tk.half) begin
        unique case (mode)
          DRPT_MODE_WAVE:  pin_lvl_ff <= (phase_ff == DRPT_PH_PRI); // RULE5
          DRPT_MODE_SHOT:  pin_lvl_ff <= (phase_ff == DRPT_PH_PRI) & ~end_pend_ff; // RULE15
          DRPT_MODE_DELAY: pin_lvl_ff <= (phase_ff == DRPT_PH_SEC) & ~end_pend_ff; // RULE20
        endcase
      end
    end
  end

  // outputs from registers, pin level XORed with the output level select input
  assign PRESCALE_STAGE_OUT       = pre_cnt_ff; // RULE21
  assign PRIMARY_COUNTER_OUT      = tmr_cnt_ff;
  assign COUNT_ACTIVE_OUT         = active_ff;
  assign ONE_SHOT_STATUS_FLAG_OUT = shot_ff;
  assign PULSE_OUTPUT_PIN_OUT     = pin_lvl_ff ^ OUTPUT_LEVEL_SELECT_IN; // RULE9
  assign IRQ_OUT                  = irq_ff;

  // counting status
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      active_ff <= 1'b0;
    end else begin
      active_ff <= running;
    end
  end
endmodule

// ===== test/drpt_pin_model.sv
// far-side model: trigger pin driver and pulse width meter
`timescale 1ns/1ps
module drpt_pin_model (
  input  wire logic        clk_in,
  input  wire logic        fire_in,
  input  wire logic        clr_in,
  input  wire logic        lvl_in,
  input  wire logic        pin_in,
  output logic             trig_out,
  output logic      [15:0] wid_out = 16'h0
);
  logic [2:0] hold_ff = 3'h0;
  // trigger pin held high six cycles per request
  always_ff @(posedge clk_in) begin
    if (fire_in) hold_ff <= 3'h6;
    else if (hold_ff != 3'h0) hold_ff <= hold_ff - 3'h1;
  end
  assign trig_out = hold_ff != 3'h0;
  // count cycles where the pin is away from its idle level
  always @(negedge clk_in) begin
    if (clr_in) wid_out <= 16'h0;
    else if (pin_in !== lvl_in) wid_out <= wid_out + 16'h1;
  end
endmodule

// ===== test/drpt_monitor.sv
// port assertions for the pulse timer
`timescale 1ns/1ps
module drpt_monitor (
  input wire logic       CLK_IN,
  input wire logic       RST_N_IN,
  input wire logic [1:0] MODE_IN,
  input wire logic       COUNT_START_BIT_IN,
  input wire logic       FORCED_STOP_WR_IN,
  input wire logic       ONE_SHOT_STOP_WR_IN,
  input wire logic       OUTPUT_LEVEL_SELECT_IN,
  input wire logic       PRE_WR_IN,
  input wire logic [7:0] WR_DATA_IN,
  input wire logic [7:0] PRESCALE_STAGE_OUT,
  input wire logic       COUNT_ACTIVE_OUT,
  input wire logic       ONE_SHOT_STATUS_FLAG_OUT,
  input wire logic       PULSE_OUTPUT_PIN_OUT,
  input wire logic       IRQ_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // interrupt, stop, idle pin and prescaler write behaviour
  property p_irq_one; IRQ_OUT |=> !IRQ_OUT; endproperty
  a_irq_one: assert property (p_irq_one) else $error("irq wider than one cycle");
  property p_stop; !COUNT_START_BIT_IN |=> !ONE_SHOT_STATUS_FLAG_OUT; endproperty
  a_stop: assert property (p_stop) else $error("flag kept after start cleared");
  property p_fstop; FORCED_STOP_WR_IN |=> !ONE_SHOT_STATUS_FLAG_OUT; endproperty
  a_fstop: assert property (p_fstop) else $error("flag kept after forced stop");
  property p_ostop; ONE_SHOT_STOP_WR_IN |=> !ONE_SHOT_STATUS_FLAG_OUT; endproperty
  a_ostop: assert property (p_ostop) else $error("flag kept after shot stop");
  property p_idle; !COUNT_START_BIT_IN [*2] |=> !COUNT_ACTIVE_OUT && !IRQ_OUT; endproperty
  a_idle: assert property (p_idle) else $error("active while stopped");
  property p_pin;
    MODE_IN == 2'h1 && !ONE_SHOT_STATUS_FLAG_OUT && !$past(ONE_SHOT_STATUS_FLAG_OUT)
      && !$past(ONE_SHOT_STATUS_FLAG_OUT, 2) |-> PULSE_OUTPUT_PIN_OUT == OUTPUT_LEVEL_SELECT_IN;
  endproperty
  a_pin: assert property (p_pin) else $error("pin not idle between shots");
  property p_irq_shot; IRQ_OUT && MODE_IN == 2'h1 |-> !ONE_SHOT_STATUS_FLAG_OUT; endproperty
  a_irq_shot: assert property (p_irq_shot) else $error("irq while shot flag set");
  property p_pre; PRE_WR_IN && !COUNT_START_BIT_IN && !COUNT_ACTIVE_OUT
    |=> PRESCALE_STAGE_OUT == $past(WR_DATA_IN); endproperty
  a_pre: assert property (p_pre) else $error("prescaler write lost");
  // main scenarios seen
  c_wave: cover property (IRQ_OUT && MODE_IN == 2'h0);
  c_delay: cover property (IRQ_OUT && MODE_IN == 2'h3);
  c_fstop: cover property (FORCED_STOP_WR_IN && ONE_SHOT_STATUS_FLAG_OUT);
endmodule

// ===== test/testbench.sv
// self-checking bench for the pulse timer
`timescale 1ns/1ps
module testbench;
  import drpt_pkg::*;
  typedef struct {logic [1:0] md, src; logic [7:0] n, m, p; logic [15:0] ex;} drpt_row_s;
  logic clk = 0, rst_n = 0, casc = 0, start = 0, fstop = 0, osst = 0, ossp = 0, lvl = 0;
  logic pre_wr = 0, pri_wr = 0, sec_wr = 0, fire = 0, clr = 0, trig, act, flag, pin, irq;
  logic [1:0] md = 2'h0, src = 2'h0, cc = 2'h0;
  logic [7:0] wd = 8'h0, pre_q, pri_q;
  logic [15:0] wid;
  int miscompares = 0, checks_done = 0, cyc = 0, c;
  drpt_row_s rows [8] = '{'{2'h1, 2'h0, 8'h0, 8'h1, 8'h0, 16'h2}, '{2'h1, 2'h0, 8'h2, 8'h3, 8'h0, 16'hc},
    '{2'h3, 2'h0, 8'h1, 8'h2, 8'h4, 16'ha}, '{2'h3, 2'h0, 8'h0, 8'h0, 8'h5, 16'h6},
    '{2'h0, 2'h0, 8'h1, 8'h2, 8'h3, 16'he}, '{2'h0, 2'h1, 8'h0, 8'h1, 8'h1, 16'h8},
    '{2'h0, 2'h2, 8'h0, 8'h0, 8'h2, 16'h20}, '{2'h0, 2'h3, 8'h1, 8'h1, 8'h0, 16'h18}};
  drpt_timer dut (.CLK_IN(clk), .RST_N_IN(rst_n), .MODE_IN(md), .SRC_SEL_IN(src), .CASC_UNDERFLOW_IN(casc),
    .COUNT_START_BIT_IN(start), .FORCED_STOP_WR_IN(fstop), .ONE_SHOT_START_WR_IN(osst),
    .ONE_SHOT_STOP_WR_IN(ossp), .OUTPUT_LEVEL_SELECT_IN(lvl), .EXTERNAL_TRIGGER_PIN_IN(trig),
    .PRE_WR_IN(pre_wr), .PRI_WR_IN(pri_wr), .SEC_WR_IN(sec_wr), .WR_DATA_IN(wd),
    .PRESCALE_STAGE_OUT(pre_q), .PRIMARY_COUNTER_OUT(pri_q), .COUNT_ACTIVE_OUT(act),
    .ONE_SHOT_STATUS_FLAG_OUT(flag), .PULSE_OUTPUT_PIN_OUT(pin), .IRQ_OUT(irq));
  drpt_pin_model far (.clk_in(clk), .fire_in(fire), .clr_in(clr), .lvl_in(lvl), .pin_in(pin),
    .trig_out(trig), .wid_out(wid));
  // clock, companion underflow every four cycles, run limit
  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cc <= cc + 2'h1;
    casc <= cc == 2'h3;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task give_verdict;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task wr(input int k, input logic [7:0] d);
    @(posedge clk) wd <= d;
    pre_wr <= k == 0;
    pri_wr <= k == 1;
    sec_wr <= k == 2;
    @(posedge clk) pre_wr <= 1'b0;
    pri_wr <= 1'b0;
    sec_wr <= 1'b0;
  endtask
  task shot;
    @(posedge clk) osst <= 1'b1;
    clr <= 1'b1;
    @(posedge clk) osst <= 1'b0;
    clr <= 1'b0;
  endtask
  task wait_irq;
    for (c = 0; c < 600 && irq !== 1'b1; c++) @(negedge clk);
  endtask
  // reset, table of waveforms, then stops, pin trigger and refusal
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk({pre_q, pri_q}, 16'hffff);
    chk({14'h0, irq, pin}, 16'h0);
    $display("reset test done");
    foreach (rows[i]) begin
      @(posedge clk) md <= rows[i].md;
      src <= rows[i].src;
      lvl <= i[0];
      wr(0, rows[i].n);
      wr(1, rows[i].m);
      wr(2, rows[i].p);
      @(posedge clk) start <= 1'b1;
      repeat (2) @(posedge clk);
      if (rows[i].md != 2'h0) begin
        shot();
        wait_irq();
        repeat (2) @(negedge clk);
        chk(wid, rows[i].ex);
      end else begin
        wait_irq();
        c = 0;
        do begin
          @(negedge clk);
          c++;
        end while (irq !== 1'b1 && c < 600);
        chk(16'(c), rows[i].ex);
      end
      @(posedge clk) start <= 1'b0;
      $display("row %0d done", i);
    end
    @(posedge clk) md <= 2'h1;
    src <= 2'h0;
    wr(0, 8'h0);
    wr(1, 8'h20);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk) start <= 1'b1;
      shot();
      repeat (6) @(posedge clk);
      ossp <= k == 0;
      start <= k != 1;
      fstop <= k == 2;
      @(posedge clk) ossp <= 1'b0;
      fstop <= 1'b0;
      start <= 1'b0;
      repeat (3) @(negedge clk);
      chk({15'h0, flag}, 16'h0);
      chk({8'h0, pri_q}, 16'h20);
      chk(16'(pin), 16'(lvl));
      $display("stop %0d done", k);
    end
    wr(1, 8'h30);
    @(posedge clk) start <= 1'b1;
    fire <= 1'b1;
    clr <= 1'b1;
    @(posedge clk) fire <= 1'b0;
    clr <= 1'b0;
    repeat (15) @(posedge clk);
    fire <= 1'b1;
    @(posedge clk) fire <= 1'b0;
    wait_irq();
    repeat (2) @(negedge clk);
    chk(wid, 16'h31);
    repeat (30) @(negedge clk);
    chk({15'h0, flag}, 16'h0);
    @(posedge clk) start <= 1'b0;
    shot();
    repeat (4) @(negedge clk);
    chk({15'h0, flag}, 16'h0);
    $display("trigger tests done");
    give_verdict();
  end
endmodule
bind drpt_timer drpt_monitor mon (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .MODE_IN(MODE_IN),
  .COUNT_START_BIT_IN(COUNT_START_BIT_IN), .FORCED_STOP_WR_IN(FORCED_STOP_WR_IN),
  .ONE_SHOT_STOP_WR_IN(ONE_SHOT_STOP_WR_IN), .OUTPUT_LEVEL_SELECT_IN(OUTPUT_LEVEL_SELECT_IN),
  .PRE_WR_IN(PRE_WR_IN), .WR_DATA_IN(WR_DATA_IN), .PRESCALE_STAGE_OUT(PRESCALE_STAGE_OUT),
  .COUNT_ACTIVE_OUT(COUNT_ACTIVE_OUT), .ONE_SHOT_STATUS_FLAG_OUT(ONE_SHOT_STATUS_FLAG_OUT),
  .PULSE_OUTPUT_PIN_OUT(PULSE_OUTPUT_PIN_OUT), .IRQ_OUT(IRQ_OUT));
